// >>> core/sar_adc_cfg.svh
// Addresses, field positions, reset values and timing counts of the
// converter start control.
// Assumes it is included once per compilation unit by core files.
`ifndef SAR_ADC_CFG_SVH
`define SAR_ADC_CFG_SVH

// Register addresses on the plain register port
`define ADDR_W          16
`define DATA_W          16
`define ADDR_MODE       16'hFF80
`define ADDR_CHAN       16'hFF81
`define ADDR_RESULT     16'hFF82

// Field positions of the mode register
`define MODE_EN_BIT     7
`define MODE_TRG_BIT    6
`define MODE_FR_HI      5
`define MODE_FR_LO      3
`define MODE_EDGE_HI    2
`define MODE_EDGE_LO    1
`define MODE_RST        8'h00

// Channel select field and reset value
`define CHAN_HI         1
`define CHAN_LO         0
`define CHAN_RST        2'h0

// Result register
`define RES_W           10
`define RES_RST         10'h000
`define RES_MSB_MASK    10'h200

// Edge select codes
`define EDGE_NONE       2'h0
`define EDGE_FALL       2'h1
`define EDGE_RISE       2'h2
`define EDGE_BOTH       2'h3

// Conversion time codes and lengths in main clock periods
`define FR_144          3'h0
`define FR_120          3'h1
`define FR_96           3'h2
`define FR_72           3'h4
`define FR_60           3'h5
`define FR_48           3'h6
`define CONV_144        144
`define CONV_120        120
`define CONV_96         96
`define CONV_72         72
`define CONV_60         60
`define CONV_48         48

// Each conversion is two sampling steps and ten comparison steps
`define STEPS_PER_CONV  12
`define SAMPLE_STEPS    2
`define LAST_STEP       4'hB
`define FIRST_STEP      4'h0
`define STEP_CNT_W      4

`endif

// >>> core/sar_adc_pkg.sv
// Types shared by the converter start control.
// Assumes sar_adc_cfg.svh supplies the widths.
`include "sar_adc_cfg.svh"

package sar_adc_pkg;

	// Control sequence of one conversion
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT_TRIG,
		ST_SAMPLE,
		ST_COMPARE
	} conv_state_type;

	// Signals driven toward the analog front end
	typedef struct packed {
		logic                  sample_hold;
		logic [1:0]            channel;
		logic [`RES_W-1:0]     tap_code;
	} analog_ctrl_type;

endpackage : sar_adc_pkg

// >>> core/sar_adc_start_control.sv
// Start, abort and successive approximation control of a four-channel
// 10-bit converter, with its mode, channel and result registers.
// Assumes an analog front end that samples the selected input while
// sample_hold is high and reports input >= tap on a comparator pin,
// and a single system clock with a plain register port.
`include "sar_adc_cfg.svh"

module sar_adc_start_control (
	input  wire logic                     clk_sys,
	input  wire logic                     rst_n,
	input  wire logic                     clk_en,
	input  wire logic [`ADDR_W-1:0]       reg_addr,
	input  wire logic [`DATA_W-1:0]       reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic      [`DATA_W-1:0]       reg_rdata,
	input  wire logic                     external_trigger_in,
	input  wire logic                     comparator_in,
	input  wire logic                     standby_req,
	output sar_adc_pkg::analog_ctrl_type  analog_ctrl,
	output logic                          conversion_busy,
	output logic                          conversion_done_irq
);

	// Register state
	logic [7:0]              converter_mode_reg_r;
	logic [7:0]              converter_mode_reg_nxt;
	logic [1:0]              channel_select_reg_r;
	logic [1:0]              channel_select_reg_nxt;
	logic [`RES_W-1:0]       conversion_result_reg_r;
	logic [`RES_W-1:0]       conversion_result_reg_nxt;
	logic [`DATA_W-1:0]      rdata_r;
	logic [`DATA_W-1:0]      rdata_nxt;

	// Sequencer state
	sar_adc_pkg::conv_state_type state_r;
	sar_adc_pkg::conv_state_type state_nxt;
	logic [`STEP_CNT_W-1:0]  step_idx_r;
	logic [`STEP_CNT_W-1:0]  step_idx_nxt;
	logic [`STEP_CNT_W-1:0]  step_cnt_r;
	logic [`STEP_CNT_W-1:0]  step_cnt_nxt;
	logic [`RES_W-1:0]       sar_r;
	logic [`RES_W-1:0]       sar_nxt;
	logic                    irq_r;
	logic                    irq_nxt;
	sar_adc_pkg::analog_ctrl_type analog_r;
	sar_adc_pkg::analog_ctrl_type analog_nxt;

	// Pin synchronisers and edge history
	logic [1:0]              trig_sync_r;
	logic                    trig_prev_r;
	logic [1:0]              cmp_sync_r;

	// Decoded controls
	logic                    wr_mode;
	logic                    wr_chan;
	logic                    en_bit;
	logic                    hw_start;
	logic [1:0]              edge_sel;
	logic [2:0]              fr_code;
	logic [7:0]              conv_len;
	logic [`STEP_CNT_W-1:0]  step_len;
	logic                    trig_edge;
	logic                    trig_rise;
	logic                    trig_fall;
	logic                    step_end;
	logic                    conv_end;
	logic [`RES_W-1:0]       trial_mask;
	logic [`RES_W-1:0]       sar_decided;

	// Register port decode
	assign wr_mode   = reg_wr && (reg_addr == `ADDR_MODE);
	assign wr_chan   = reg_wr && (reg_addr == `ADDR_CHAN);

	// Mode fields
	assign en_bit   = converter_mode_reg_r[`MODE_EN_BIT];
	assign hw_start = converter_mode_reg_r[`MODE_TRG_BIT];
	assign edge_sel = converter_mode_reg_r[`MODE_EDGE_HI:`MODE_EDGE_LO];
	assign fr_code  = converter_mode_reg_r[`MODE_FR_HI:`MODE_FR_LO];

	// Conversion length per time code; prohibited codes fall back to 144
	always_comb begin
		case (fr_code)
			`FR_144: conv_len = 8'(`CONV_144);
			`FR_120: conv_len = 8'(`CONV_120);
			`FR_96:  conv_len = 8'(`CONV_96);
			`FR_72:  conv_len = 8'(`CONV_72);
			`FR_60:  conv_len = 8'(`CONV_60);
			`FR_48:  conv_len = 8'(`CONV_48);
			default: conv_len = 8'(`CONV_144);
		endcase
	end

	// Clocks per step: the conversion length spread over twelve steps
	assign step_len = `STEP_CNT_W'(conv_len / 8'(`STEPS_PER_CONV));

	// Edge detection on the synchronised trigger pin
	assign trig_rise = trig_sync_r[1] && !trig_prev_r;
	assign trig_fall = !trig_sync_r[1] && trig_prev_r;
	always_comb begin
		case (edge_sel)
			`EDGE_NONE: trig_edge = 1'b0;
			`EDGE_FALL: trig_edge = trig_fall;
			`EDGE_RISE: trig_edge = trig_rise;
			`EDGE_BOTH: trig_edge = trig_rise || trig_fall;
			default:    trig_edge = 1'b0;
		endcase
	end

	// Step timing and the bit under trial, MSB first
	assign step_end   = (step_cnt_r == step_len - `STEP_CNT_W'(1));
	assign conv_end   = step_end && (step_idx_r == `LAST_STEP);
	assign trial_mask = (state_r == sar_adc_pkg::ST_COMPARE) ?
		(`RES_MSB_MASK >> (step_idx_r - `STEP_CNT_W'(`SAMPLE_STEPS))) :
		`RES_W'(0);
	assign sar_decided = cmp_sync_r[1] ? (sar_r | trial_mask) : sar_r;

	// Register file next values
	always_comb begin
		converter_mode_reg_nxt    = converter_mode_reg_r;
		channel_select_reg_nxt    = channel_select_reg_r;
		conversion_result_reg_nxt = conversion_result_reg_r;
		rdata_nxt                 = '0;
		irq_nxt                   = 1'b0;
		if (wr_mode) begin
			converter_mode_reg_nxt = reg_wdata[7:0];
		end
		if (wr_chan) begin
			channel_select_reg_nxt = reg_wdata[`CHAN_HI:`CHAN_LO];
		end
		// Result write at completion unless a mode or channel write or a standby request coincides
		if (state_r == sar_adc_pkg::ST_COMPARE && conv_end &&
			en_bit && !standby_req) begin
			if (!wr_mode && !wr_chan) begin
				conversion_result_reg_nxt = sar_decided;
				irq_nxt                   = 1'b1;
			end
		end
		// Read data from current values: a coinciding read sees the old one
		if (reg_rd) begin
			case (reg_addr)
				`ADDR_MODE:   rdata_nxt = `DATA_W'(converter_mode_reg_r);
				`ADDR_CHAN:   rdata_nxt = `DATA_W'(channel_select_reg_r);
				`ADDR_RESULT: rdata_nxt = `DATA_W'(conversion_result_reg_r);
				default:      rdata_nxt = '0;
			endcase
		end
	end

	// Sequencer next values
	always_comb begin
		state_nxt    = state_r;
		step_idx_nxt = step_idx_r;
		step_cnt_nxt = step_cnt_r;
		sar_nxt      = sar_r;
		case (state_r)
			sar_adc_pkg::ST_IDLE: begin
				if (en_bit && !standby_req) begin
					if (hw_start) begin
						state_nxt = sar_adc_pkg::ST_WAIT_TRIG;
					end else begin
						state_nxt = sar_adc_pkg::ST_SAMPLE;
					end
				end
			end
			sar_adc_pkg::ST_WAIT_TRIG: begin
				if (trig_edge) begin
					state_nxt = sar_adc_pkg::ST_SAMPLE;
				end
			end
			sar_adc_pkg::ST_SAMPLE: begin
				step_cnt_nxt = step_cnt_r + `STEP_CNT_W'(1);
				if (step_end) begin
					step_cnt_nxt = '0;
					step_idx_nxt = step_idx_r + `STEP_CNT_W'(1);
					if (step_idx_r == `STEP_CNT_W'(`SAMPLE_STEPS - 1)) begin
						state_nxt = sar_adc_pkg::ST_COMPARE;
					end
				end
			end
			sar_adc_pkg::ST_COMPARE: begin
				step_cnt_nxt = step_cnt_r + `STEP_CNT_W'(1);
				if (step_end) begin
					step_cnt_nxt = '0;
					step_idx_nxt = step_idx_r + `STEP_CNT_W'(1);
					sar_nxt      = sar_decided;
					if (conv_end) begin
						if (hw_start) begin
							state_nxt = sar_adc_pkg::ST_WAIT_TRIG;
						end else begin
							state_nxt = sar_adc_pkg::ST_SAMPLE;
						end
					end
				end
			end
			default: state_nxt = sar_adc_pkg::ST_IDLE;
		endcase
		// Fresh conversion on every entry to sampling from another state
		if (state_nxt == sar_adc_pkg::ST_SAMPLE &&
			state_r != sar_adc_pkg::ST_SAMPLE) begin
			step_idx_nxt = `FIRST_STEP;
			step_cnt_nxt = '0;
			sar_nxt      = '0;
		end
		// Writes to mode or channel abort or restart the conversion
		if (wr_mode || wr_chan) begin
			step_idx_nxt = `FIRST_STEP;
			step_cnt_nxt = '0;
			sar_nxt      = '0;
			if (wr_mode && !reg_wdata[`MODE_EN_BIT]) begin
				state_nxt = sar_adc_pkg::ST_IDLE;
			end else if (wr_mode ? reg_wdata[`MODE_TRG_BIT] : hw_start) begin
				if (en_bit || wr_mode) begin
					state_nxt = sar_adc_pkg::ST_WAIT_TRIG;
				end
			end else if (en_bit || wr_mode) begin
				state_nxt = sar_adc_pkg::ST_SAMPLE;
			end
		end
		// Clearing enable or entering standby stops without a result
		if (!en_bit && !wr_mode) begin
			state_nxt = sar_adc_pkg::ST_IDLE;
		end
		if (standby_req) begin
			state_nxt = sar_adc_pkg::ST_IDLE;
		end
	end

	// Analog front end drive for the coming cycle
	always_comb begin
		analog_nxt.channel     = channel_select_reg_nxt;
		analog_nxt.sample_hold = (state_nxt == sar_adc_pkg::ST_SAMPLE);
		if (state_nxt == sar_adc_pkg::ST_COMPARE) begin
			analog_nxt.tap_code = sar_nxt | (`RES_MSB_MASK >>
				(step_idx_nxt - `STEP_CNT_W'(`SAMPLE_STEPS)));
		end else begin
			analog_nxt.tap_code = '0;
		end
	end

	// Registers: register file, sequencer, analog drive
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			converter_mode_reg_r    <= `MODE_RST;
			channel_select_reg_r    <= `CHAN_RST;
			conversion_result_reg_r <= `RES_RST;
			rdata_r                 <= '0;
			irq_r                   <= 1'b0;
			state_r                 <= sar_adc_pkg::ST_IDLE;
			step_idx_r              <= `FIRST_STEP;
			step_cnt_r              <= '0;
			sar_r                   <= '0;
			analog_r                <= '0;
		end else if (clk_en) begin
			converter_mode_reg_r    <= converter_mode_reg_nxt;
			channel_select_reg_r    <= channel_select_reg_nxt;
			conversion_result_reg_r <= conversion_result_reg_nxt;
			rdata_r                 <= rdata_nxt;
			irq_r                   <= irq_nxt;
			state_r                 <= state_nxt;
			step_idx_r              <= step_idx_nxt;
			step_cnt_r              <= step_cnt_nxt;
			sar_r                   <= sar_nxt;
			analog_r                <= analog_nxt;
		end
	end

	// Two-stage synchronisers for the pins; edge history after them
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			trig_sync_r <= 2'h0;
			trig_prev_r <= 1'b0;
			cmp_sync_r  <= 2'h0;
		end else if (clk_en) begin
			trig_sync_r <= {trig_sync_r[0], external_trigger_in};
			trig_prev_r <= trig_sync_r[1];
			cmp_sync_r  <= {cmp_sync_r[0], comparator_in};
		end
	end

	// Outputs
	assign reg_rdata           = rdata_r;
	assign analog_ctrl         = analog_r;
	assign conversion_done_irq = irq_r;
	assign conversion_busy     = (state_r == sar_adc_pkg::ST_SAMPLE) ||
		(state_r == sar_adc_pkg::ST_COMPARE);

endmodule : sar_adc_start_control

// >>> test/sar_adc_front_model.sv
// Analog front end: four input levels, sample switch and comparator.
// Assumes levels are codes already offset half a step by the ladder.
module sar_adc_front_model (
	input  wire logic                          clk_sys,
	input  wire sar_adc_pkg::analog_ctrl_type  analog_ctrl,
	input  wire logic [3:0][9:0]               level,
	output logic                               comparator_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] held_r = 10'h000;
	// Follow the selected input while sampling, hold it afterwards
	always @(posedge clk_sys) begin
		if (analog_ctrl.sample_hold) held_r <= level[analog_ctrl.channel];
	end
	// High while the held input is at or above the trial tap
	assign comparator_in = held_r >= analog_ctrl.tap_code;
endmodule : sar_adc_front_model

// >>> test/sar_adc_start_control_assertions.sv
// Checker on the ports of the converter start control.
// Assumes clk_en is never low while a completion pulse stands, and
// that the package is compiled first.
`include "sar_adc_cfg.svh"
module sar_adc_start_control_checker (
	input wire logic                          clk_sys,
	input wire logic                          rst_n,
	input wire logic [`ADDR_W-1:0]            reg_addr,
	input wire logic [`DATA_W-1:0]            reg_wdata,
	input wire logic                          reg_wr,
	input wire logic                          reg_rd,
	input wire logic [`DATA_W-1:0]            reg_rdata,
	input wire logic                          standby_req,
	input wire sar_adc_pkg::analog_ctrl_type  analog_ctrl,
	input wire logic                          conversion_busy,
	input wire logic                          conversion_done_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] gap_r;
	logic [7:0] gap_nxt;
	wire logic rd_res = reg_rd && reg_addr == `ADDR_RESULT;
	wire logic cfg_wr = reg_wr && (reg_addr == `ADDR_MODE ||
		reg_addr == `ADDR_CHAN);
	// Cycles since the last completion, saturating
	always_comb gap_nxt = conversion_done_irq ? 8'h00 :
		gap_r + 8'(gap_r != 8'hFF);
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) gap_r <= 8'hFF;
		else gap_r <= gap_nxt;
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// Completion is a single pulse out of a running conversion
	property p_irq_pulse;
		conversion_done_irq |=> !conversion_done_irq;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse)
		else $error("completion pulse too long");
	property p_irq_busy;
		conversion_done_irq |-> $past(conversion_busy);
	endproperty
	a_irq_busy: assert property (p_irq_busy)
		else $error("completion without conversion");
	property p_irq_gap;
		conversion_done_irq |-> gap_r >= 8'h2F;
	endproperty
	a_irq_gap: assert property (p_irq_gap)
		else $error("conversion shorter than 48 clocks");
	// Read data only in the cycle after a read
	property p_rdata_idle;
		!$past(reg_rd) |-> reg_rdata == '0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data outside read cycle");
	property p_res_hold;
		rd_res && !conversion_done_irq ##1 rd_res && !conversion_done_irq
			|=> reg_rdata == $past(reg_rdata);
	endproperty
	a_res_hold: assert property (p_res_hold)
		else $error("result changed without completion");
	property p_en_off;
		reg_wr && reg_addr == `ADDR_MODE && !reg_wdata[`MODE_EN_BIT]
			|=> !conversion_busy;
	endproperty
	a_en_off: assert property (p_en_off)
		else $error("conversion runs after disable");
	property p_wr_drop;
		cfg_wr |=> !conversion_done_irq;
	endproperty
	a_wr_drop: assert property (p_wr_drop)
		else $error("completion beside register write");
	property p_standby;
		standby_req |=> !conversion_busy;
	endproperty
	a_standby: assert property (p_standby)
		else $error("conversion runs in standby");
	property p_chan_stable;
		(conversion_busy && !reg_wr) [*4] |-> $stable(analog_ctrl.channel);
	endproperty
	a_chan_stable: assert property (p_chan_stable)
		else $error("channel changed inside conversion");
endmodule : sar_adc_start_control_checker
bind sar_adc_start_control sar_adc_start_control_checker
	u_sar_adc_start_control_checker (.clk_sys(clk_sys), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .standby_req(standby_req),
	.analog_ctrl(analog_ctrl), .conversion_busy(conversion_busy),
	.conversion_done_irq(conversion_done_irq));

// >>> test/sar_adc_start_control_tb_top.sv
// Self-checking bench of the converter start control.
// Assumes package, core files and checker are compiled before it.
`include "sar_adc_cfg.svh"
`define CHK(g, e) begin \
	samples_checked++; \
	if ((g) !== (e)) begin \
		num_errors++; \
		$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
	end \
end
module sar_adc_start_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, rst_n, clk_en, reg_wr, reg_rd, trig, standby_req;
	logic [15:0] reg_addr, reg_wdata, reg_rdata;
	logic comparator_in, conversion_busy, conversion_done_irq;
	logic [3:0][9:0] level;
	sar_adc_pkg::analog_ctrl_type analog_ctrl;
	logic [31:0] seed = 32'h0000_d45f;
	int num_errors = 0;
	int samples_checked = 0;
	int lvl[4];
	// Time codes; code 3 is prohibited and runs as the longest length
	int codes[7] = '{0, 3, 1, 2, 4, 5, 6};
	int lens[7] = '{144, 144, 120, 96, 72, 60, 48};
	sar_adc_start_control u_sar_adc_start_control (.clk_sys(clk_sys),
		.rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .external_trigger_in(trig),
		.comparator_in(comparator_in), .standby_req(standby_req),
		.analog_ctrl(analog_ctrl), .conversion_busy(conversion_busy),
		.conversion_done_irq(conversion_done_irq));
	sar_adc_front_model u_sar_adc_front_model (.clk_sys(clk_sys),
		.analog_ctrl(analog_ctrl), .level(level),
		.comparator_in(comparator_in));
	// Clock and random source
	always #4 clk_sys = ~clk_sys;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	// Reads held n cycles back to back, each answer compared
	task automatic rd_chk(input logic [15:0] a, input int n,
		input logic [15:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys);
			if (i == n - 1) reg_rd <= 1'b0;
			@(negedge clk_sys);
			`CHK(reg_rdata, e)
		end
	endtask : rd_chk
	task automatic wait_irq(input int lim, output int n);
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (conversion_done_irq !== 1'b1 && n < lim);
	endtask : wait_irq
	task automatic report_and_stop();
		if (num_errors == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		#(8 * 40000);
		num_errors++;
		report_and_stop();
	end
	// Main sequence
	initial begin
		int n;
		{clk_sys, rst_n, reg_wr, reg_rd, trig, standby_req} = '0;
		{reg_addr, reg_wdata} = '0;
		clk_en = 1'b1;
		for (int i = 0; i < 4; i++) begin
			lvl[i] = int'(rnd() & 32'h0000_03FF);
			level[i] = 10'(lvl[i]);
		end
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		wr(`ADDR_RESULT, 16'h03FF);
		wr(16'hFF83, 16'h00FF);
		for (int a = 0; a < 4; a++) rd_chk(16'hFF80 + 16'(a), 1, 16'h0000);
		for (int k = 0; k < 7; k++) begin
			wr(`ADDR_CHAN, 16'(k % 4));
			wr(`ADDR_MODE, 16'h0080 | 16'(codes[k] << 3));
			// Read in the completion cycle sees the previous result
			repeat (lens[k] - 2) @(posedge clk_sys);
			rd_chk(`ADDR_RESULT, 1, 16'(k ? lvl[(k - 1) % 4] : 0));
			`CHK(conversion_done_irq, 1'b1)
			wait_irq(400, n);
			`CHK(n, lens[k])
			rd_chk(`ADDR_RESULT, 3, 16'(lvl[k % 4]));
		end
		for (int j = 0; j < 3; j++) begin
			wait_irq(400, n);
			repeat (j == 2 ? 46 : 20) @(posedge clk_sys);
			wr(j == 0 ? `ADDR_CHAN : `ADDR_MODE, j == 0 ? 16'h0003 : 16'h00B0);
			wait_irq(400, n);
			`CHK(n > 40, 1'b1)
		end
		rd_chk(`ADDR_RESULT, 2, 16'(lvl[3]));
		repeat (20) @(posedge clk_sys);
		wr(`ADDR_MODE, 16'h0030);
		wait_irq(300, n);
		`CHK(n, 300)
		for (int e = 0; e < 4; e++) begin
			wr(`ADDR_MODE, 16'h00F0 | 16'(e << 1));
			wait_irq(100, n);
			`CHK(n, 100)
			@(posedge clk_sys) trig <= 1'b1;
			repeat (10) @(posedge clk_sys);
			trig <= 1'b0;
			wait_irq(150, n);
			`CHK(n < 150, e != 0)
			if (e != 0) `CHK(n > 48, e == 1)
			wait_irq(200, n);
			`CHK(n, 200)
		end
		wr(`ADDR_MODE, 16'h00F4);
		for (int j = 0; j < 3; j++) begin
			@(posedge clk_sys) trig <= 1'b1;
			repeat (20) @(posedge clk_sys);
			if (j == 0) wr(`ADDR_CHAN, 16'h0002);
			if (j == 1) wr(`ADDR_MODE, 16'h00F4);
			wait_irq(200, n);
			`CHK(n < 200, j == 2)
			@(posedge clk_sys) trig <= 1'b0;
		end
		rd_chk(`ADDR_RESULT, 1, 16'(lvl[2]));
		wr(`ADDR_MODE, 16'h00B0);
		repeat (20) @(posedge clk_sys);
		standby_req <= 1'b1;
		wait_irq(200, n);
		`CHK(n, 200)
		@(posedge clk_sys) standby_req <= 1'b0;
		wait_irq(200, n);
		`CHK(n < 200, 1'b1)
		// Clock enable low for 30 cycles stretches the next period by 30
		repeat (10) @(posedge clk_sys);
		clk_en <= 1'b0;
		repeat (30) @(posedge clk_sys);
		clk_en <= 1'b1;
		wait_irq(200, n);
		`CHK(n, 39)
		rd_chk(`ADDR_RESULT, 1, 16'(lvl[2]));
		report_and_stop();
	end
endmodule : sar_adc_start_control_tb_top
